// *** verilog/isr_pkg.sv ***
// Shared constants and types for the two-wire slave receive block.
package isr_pkg;
  // Mode codes for port_mode_select: bit 0 picks 10-bit addressing, bit 1 Start/Stop interrupts.
  localparam logic [1:0] MODE_7BIT = 2'h0;
  localparam logic [1:0] MODE_10BIT = 2'h1;
  localparam logic [1:0] MODE_7BIT_SP = 2'h2;
  localparam logic [1:0] MODE_10BIT_SP = 2'h3;
  localparam int MODE_TEN_BIT = 0;
  localparam int MODE_SP_BIT = 1;

  // Field positions of the configuration word carried into the link domain.
  localparam int CFG_W = 9;
  localparam int CFG_START_IE = 0;
  localparam int CFG_STOP_IE = 1;
  localparam int CFG_ADDRESS_HOLD_ENABLE = 2;
  localparam int CFG_DATA_HOLD_ENABLE = 3;
  localparam int CFG_SEN = 4;
  localparam int CFG_BUFFER_OVERWRITE_ENABLE = 5;
  localparam int CFG_ACKVAL = 6;
  localparam int CFG_MODE_LO = 7;
  localparam int CFG_MODE_HI = 8;

  // Software event toggles sent into the link domain.
  localparam int EV_W = 5;
  localparam int EV_ADDR = 0;
  localparam int EV_REL = 1;
  localparam int EV_IRQCLR = 2;
  localparam int EV_RD = 3;
  localparam int EV_OVCLR = 4;

  // Field positions of the status word returned to the system domain.
  localparam int ST_W = 11;
  localparam int ST_IRQ = 0;
  localparam int ST_BF = 1;
  localparam int ST_OV = 2;
  localparam int ST_RACK = 3;
  localparam int ST_ACKT = 4;
  localparam int ST_UA = 5;
  localparam int ST_START = 6;
  localparam int ST_STOP = 7;
  localparam int ST_RW = 8;
  localparam int ST_DNA = 9;
  localparam int ST_CKP = 10;

  localparam logic [4:0] TEN_HI_PATTERN = 5'h1E;
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;
  localparam logic [7:0] OWN_ADDR_RST = 8'h00;
  localparam logic CKP_RST = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_LO = 3'b010,
    ST_DATA = 3'b011,
    ST_READ = 3'b100,
    ST_IGNORE = 3'b101
  } isr_state_t;
endpackage

// *** verilog/isr_slave.sv ***
// Two-wire slave receiver with own-address matching, acknowledge control and clock stretching.
//
// Overview of operation
// - Start or Stop raises the port interrupt when its enable is set.
// - The ninth clock is the acknowledge slot; receiver pulls data low.
// - Acknowledge level sampled in the ninth pulse is kept in received_ack_flag.
// - With a hold option on, the acknowledge sent is software's ack_value_select.
// - With both hold options off, hardware acknowledges bytes itself.
// - Buffer full or overflow gives not-acknowledge; overwrite enable alters this.
// - ack_phase_flag is set after the eighth fall, only with hold options.
// - Four modes: 7 or 10 bit, each with or without Start/Stop interrupts.
// - First byte after Start is matched; match loads buffer, mismatch goes to ST_IGNORE until the next Start or Stop.
// - In 7-bit mode the read/write bit is ignored in the match.
// - 10-bit high byte matches 11110, own bits 2:1, then zero.
// - After a matching write high byte, flag update needed and hold clock.
// - Low byte compares all bits; mismatch still interrupts and holds; writes clear.
// - 10-bit read needs prior full write match, then Restart with high byte.
// - Matching write address clears read/write, loads buffer and acknowledges.
// - Every transferred byte sets the sticky port interrupt flag.
// - With stretch enable, clock held after each acknowledged byte until release is set.
// - Reading the shift buffer clears buffer_full.
// - Start sets start flag; Stop sets stop flag and bus goes idle.
// - Hold options: after eighth fall, interrupt and clear clock_release.
// - Hold options: after ninth fall interrupt only on acknowledge or when address update is needed, then stretch with stretch enable or on a read.
// - Start is data falling while clock is high.
// - Stop is data rising while clock is high.
// - A Restart resets receive logic like a Start and expects an address.
// - Data changes while clock low and is sampled on the rising edge.
`timescale 1ns/1ps
module isr_slave
  import isr_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic link_clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe_o,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [1:0] port_mode_select_i,
  input wire logic start_irq_enable_i,
  input wire logic stop_irq_enable_i,
  input wire logic address_hold_enable_i,
  input wire logic data_hold_enable_i,
  input wire logic stretch_enable_i,
  input wire logic buffer_overwrite_enable_i,
  input wire logic ack_value_select_i,
  input wire logic own_address_wr_i,
  input wire logic [7:0] own_address_i,
  input wire logic clock_release_set_i,
  input wire logic port_interrupt_clr_i,
  input wire logic shift_buffer_rd_i,
  input wire logic receive_overflow_clr_i,
  output logic [7:0] shift_buffer_o,
  output logic port_interrupt_flag_o,
  output logic buffer_full_o,
  output logic receive_overflow_o,
  output logic received_ack_flag_o,
  output logic ack_phase_flag_o,
  output logic address_update_needed_o,
  output logic start_detected_o,
  output logic stop_detected_o,
  output logic read_write_o,
  output logic data_not_address_o,
  output logic clock_release_o
);
  import isr_pkg::*;

  typedef struct packed {
    logic [CFG_W-1:0] cfg;
    logic [EV_W-1:0] ev_tog;
    logic [7:0] own_addr;
    logic [ST_W-1:0] st_s1;
    logic [ST_W-1:0] st_s2;
    logic dt_s1;
    logic dt_s2;
    logic dt_s3;
    logic [7:0] rx_data;
  } isr_sys_t;

  typedef struct packed {
    logic [CFG_W-1:0] cfg_s1;
    logic [CFG_W-1:0] cfg_s2;
    logic [EV_W-1:0] ev_s1;
    logic [EV_W-1:0] ev_s2;
    logic [EV_W-1:0] ev_s3;
    logic scl_s1;
    logic scl_s2;
    logic sda_s1;
    logic sda_s2;
    logic scl_d;
    logic sda_d;
    isr_state_t state;
    isr_state_t next_st;
    logic [2:0] bitcnt;
    logic [7:0] shift;
    logic [7:0] buffer;
    logic [7:0] own;
    logic data_tog;
    logic in_ack;
    logic use_sw;
    logic hold_byte;
    logic ua_at9;
    logic stretch_at9;
    logic seen_low;
    logic prior;
    logic irq;
    logic bf;
    logic ov;
    logic rack;
    logic ackt;
    logic ua;
    logic start;
    logic stop;
    logic rw;
    logic dna;
    logic clock_release;
    logic sda_oe;
    logic scl_oe;
  } isr_link_t;

  isr_sys_t s_reg;
  isr_sys_t s_next;
  isr_link_t l_reg;
  isr_link_t l_next;

  logic [CFG_W-1:0] cfg;
  logic [EV_W-1:0] ev;
  logic [ST_W-1:0] st_vec;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic active;
  logic byte_end;
  logic ack_end;

  // Status word as the link domain sees it; only the first sync flop reads it.
  always_comb
  begin
    st_vec = '0;
    st_vec[ST_IRQ] = l_reg.irq;
    st_vec[ST_BF] = l_reg.bf;
    st_vec[ST_OV] = l_reg.ov;
    st_vec[ST_RACK] = l_reg.rack;
    st_vec[ST_ACKT] = l_reg.ackt;
    st_vec[ST_UA] = l_reg.ua;
    st_vec[ST_START] = l_reg.start;
    st_vec[ST_STOP] = l_reg.stop;
    st_vec[ST_RW] = l_reg.rw;
    st_vec[ST_DNA] = l_reg.dna;
    st_vec[ST_CKP] = l_reg.clock_release;
  end

  // System side: software strobes become toggles, link status returns through two flops.
  always_comb
  begin
    s_next = s_reg;
    s_next.cfg = {port_mode_select_i, ack_value_select_i, buffer_overwrite_enable_i,
                  stretch_enable_i, data_hold_enable_i, address_hold_enable_i,
                  stop_irq_enable_i, start_irq_enable_i};
    if (own_address_wr_i)
    begin
      s_next.own_addr = own_address_i;
      s_next.ev_tog[EV_ADDR] = ~s_reg.ev_tog[EV_ADDR];
    end
    if (clock_release_set_i)
      s_next.ev_tog[EV_REL] = ~s_reg.ev_tog[EV_REL];
    if (port_interrupt_clr_i)
      s_next.ev_tog[EV_IRQCLR] = ~s_reg.ev_tog[EV_IRQCLR];
    if (shift_buffer_rd_i)
      s_next.ev_tog[EV_RD] = ~s_reg.ev_tog[EV_RD];
    if (receive_overflow_clr_i)
      s_next.ev_tog[EV_OVCLR] = ~s_reg.ev_tog[EV_OVCLR];
    s_next.st_s1 = st_vec;
    s_next.st_s2 = s_reg.st_s1;
    s_next.dt_s1 = l_reg.data_tog;
    s_next.dt_s2 = s_reg.dt_s1;
    s_next.dt_s3 = s_reg.dt_s2;
    // The link buffer is stable for a whole byte time after its toggle flips.
    if (s_reg.dt_s2 ^ s_reg.dt_s3)
      s_next.rx_data = l_reg.buffer;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      s_reg <= '0;
      s_reg.own_addr <= OWN_ADDR_RST;
      s_reg.st_s1[ST_CKP] <= CKP_RST;
      s_reg.st_s2[ST_CKP] <= CKP_RST;
    end
    else
      s_reg <= s_next;
  end

  assign cfg = l_reg.cfg_s2;
  assign ev = l_reg.ev_s2 ^ l_reg.ev_s3;
  assign scl_rise = l_reg.scl_s2 & ~l_reg.scl_d;
  assign scl_fall = ~l_reg.scl_s2 & l_reg.scl_d;
  assign start_det = l_reg.scl_s2 & l_reg.scl_d & l_reg.sda_d & ~l_reg.sda_s2;
  assign stop_det = l_reg.scl_s2 & l_reg.scl_d & ~l_reg.sda_d & l_reg.sda_s2 & l_reg.seen_low;
  assign active = (l_reg.state == ST_ADDR) || (l_reg.state == ST_ADDR_LO) ||
                  (l_reg.state == ST_DATA);
  assign byte_end = active & scl_fall & ~l_reg.in_ack & (l_reg.bitcnt == LAST_DATA_BIT);
  assign ack_end = active & scl_fall & l_reg.in_ack;

  // Link side: bus sampling, byte framing and acknowledge, all on the link clock.
  always_comb
  begin
    logic sp_mode;
    logic ten;
    logic ovf;
    logic hi_ok;
    logic match;
    logic lo_miss;
    logic hold;
    logic acked;
    sp_mode = cfg[CFG_MODE_HI];
    ten = cfg[CFG_MODE_LO];
    ovf = cfg[CFG_BUFFER_OVERWRITE_ENABLE] ? l_reg.ov : (l_reg.bf | l_reg.ov);
    hi_ok = (l_reg.shift[7:3] == TEN_HI_PATTERN) && (l_reg.shift[2:1] == l_reg.own[2:1]);
    match = 1'b0;
    lo_miss = 1'b0;
    hold = 1'b0;
    acked = l_reg.sda_oe;
    l_next = l_reg;
    l_next.cfg_s1 = s_reg.cfg;
    l_next.cfg_s2 = l_reg.cfg_s1;
    l_next.ev_s1 = s_reg.ev_tog;
    l_next.ev_s2 = l_reg.ev_s1;
    l_next.ev_s3 = l_reg.ev_s2;
    l_next.scl_s1 = scl_i;
    l_next.scl_s2 = l_reg.scl_s1;
    l_next.sda_s1 = sda_i;
    l_next.sda_s2 = l_reg.sda_s1;
    l_next.scl_d = l_reg.scl_s2;
    l_next.sda_d = l_reg.sda_s2;
    if (!l_reg.scl_s2)
      l_next.seen_low = 1'b1;
    // Software clears come first so that a hardware set in the same cycle wins.
    if (ev[EV_ADDR])
    begin
      l_next.own = s_reg.own_addr;
      l_next.ua = 1'b0;
    end
    if (ev[EV_REL])
      l_next.clock_release = 1'b1;
    if (ev[EV_IRQCLR])
      l_next.irq = 1'b0;
    if (ev[EV_RD])
      l_next.bf = 1'b0;
    if (ev[EV_OVCLR])
      l_next.ov = 1'b0;
    if (start_det)
    begin
      l_next.state = ST_ADDR;
      l_next.bitcnt = '0;
      l_next.in_ack = 1'b0;
      l_next.sda_oe = 1'b0;
      l_next.ackt = 1'b0;
      l_next.seen_low = 1'b0;
      l_next.start = 1'b1;
      l_next.stop = 1'b0;
      if (sp_mode || cfg[CFG_START_IE])
        l_next.irq = 1'b1;
    end
    else if (stop_det)
    begin
      l_next.state = ST_IDLE;
      l_next.in_ack = 1'b0;
      l_next.sda_oe = 1'b0;
      l_next.ackt = 1'b0;
      l_next.prior = 1'b0;
      l_next.stop = 1'b1;
      l_next.start = 1'b0;
      if (sp_mode || cfg[CFG_STOP_IE])
        l_next.irq = 1'b1;
    end
    else if (active)
    begin
      if (scl_rise && !l_reg.in_ack)
        l_next.shift = {l_reg.shift[6:0], l_reg.sda_s2};
      if (scl_rise && l_reg.in_ack)
        l_next.rack = l_reg.sda_s2;
      if (l_reg.in_ack && l_reg.use_sw)
        l_next.sda_oe = ~cfg[CFG_ACKVAL];
      if (ack_end)
      begin
        l_next.in_ack = 1'b0;
        l_next.sda_oe = 1'b0;
        l_next.ackt = 1'b0;
        l_next.bitcnt = '0;
        l_next.state = l_reg.next_st;
        if (!l_reg.hold_byte || acked || l_reg.ua_at9)
          l_next.irq = 1'b1;
        if (l_reg.ua_at9)
          l_next.ua = 1'b1;
        if (acked && l_reg.stretch_at9)
          l_next.clock_release = 1'b0;
      end
      else if (byte_end)
      begin
        l_next.ua_at9 = 1'b0;
        l_next.dna = (l_reg.state == ST_DATA);
        case (l_reg.state)
          ST_ADDR:
          begin
            hold = cfg[CFG_ADDRESS_HOLD_ENABLE];
            if (!ten)
            begin
              match = (l_reg.shift[7:1] == l_reg.own[7:1]);
              l_next.next_st = l_reg.shift[0] ? ST_READ : ST_DATA;
            end
            else if (hi_ok && !l_reg.shift[0])
            begin
              match = 1'b1;
              l_next.prior = 1'b0;
              l_next.ua_at9 = 1'b1;
              l_next.next_st = ST_ADDR_LO;
            end
            else if (hi_ok && l_reg.prior)
            begin
              match = 1'b1;
              l_next.next_st = ST_READ;
            end
            else
              l_next.prior = 1'b0;
            if (match)
              l_next.rw = l_reg.shift[0];
          end
          ST_ADDR_LO:
          begin
            hold = cfg[CFG_ADDRESS_HOLD_ENABLE];
            match = 1'b1;
            lo_miss = (l_reg.shift != l_reg.own);
            l_next.ua_at9 = 1'b1;
            l_next.prior = ~lo_miss;
            l_next.next_st = lo_miss ? ST_IGNORE : ST_DATA;
          end
          ST_DATA:
          begin
            hold = cfg[CFG_DATA_HOLD_ENABLE];
            match = 1'b1;
            l_next.next_st = ST_DATA;
          end
          default:
          begin
            hold = 1'b0;
          end
        endcase
        if (!match)
          l_next.state = ST_IGNORE;
        else
        begin
          l_next.in_ack = 1'b1;
          l_next.hold_byte = hold;
          l_next.use_sw = hold;
          l_next.stretch_at9 = (l_next.next_st == ST_READ) ||
                               (cfg[CFG_SEN] && (l_next.next_st == ST_DATA));
          if (!lo_miss && !ovf)
          begin
            l_next.buffer = l_reg.shift;
            l_next.bf = 1'b1;
            l_next.data_tog = ~l_reg.data_tog;
          end
          if (!lo_miss && l_reg.bf)
            l_next.ov = 1'b1;
          if (hold)
          begin
            l_next.irq = 1'b1;
            l_next.clock_release = 1'b0;
            l_next.ackt = 1'b1;
            l_next.sda_oe = ~cfg[CFG_ACKVAL];
          end
          else
            l_next.sda_oe = ~(ovf | lo_miss);
        end
      end
      // The fall that closes a Start or Restart carries no bit, so it is not counted.
      else if (scl_fall && l_reg.seen_low)
        l_next.bitcnt = l_reg.bitcnt + 3'h1;
    end
    l_next.scl_oe = ~l_next.clock_release | l_next.ua;
  end

  always_ff @(posedge link_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      l_reg <= '0;
      l_reg.scl_s1 <= 1'b1;
      l_reg.scl_s2 <= 1'b1;
      l_reg.sda_s1 <= 1'b1;
      l_reg.sda_s2 <= 1'b1;
      l_reg.scl_d <= 1'b1;
      l_reg.sda_d <= 1'b1;
      l_reg.state <= ST_IDLE;
      l_reg.next_st <= ST_IDLE;
      l_reg.own <= OWN_ADDR_RST;
      l_reg.clock_release <= CKP_RST;
    end
    else
      l_reg <= l_next;
  end

  // Lines are pulled low only; the level itself is always zero.
  assign sda_o = 1'b0;
  assign scl_o = 1'b0;
  assign sda_oe_o = l_reg.sda_oe;
  assign scl_oe_o = l_reg.scl_oe;
  assign shift_buffer_o = s_reg.rx_data;
  assign port_interrupt_flag_o = s_reg.st_s2[ST_IRQ];
  assign buffer_full_o = s_reg.st_s2[ST_BF];
  assign receive_overflow_o = s_reg.st_s2[ST_OV];
  assign received_ack_flag_o = s_reg.st_s2[ST_RACK];
  assign ack_phase_flag_o = s_reg.st_s2[ST_ACKT];
  assign address_update_needed_o = s_reg.st_s2[ST_UA];
  assign start_detected_o = s_reg.st_s2[ST_START];
  assign stop_detected_o = s_reg.st_s2[ST_STOP];
  assign read_write_o = s_reg.st_s2[ST_RW];
  assign data_not_address_o = s_reg.st_s2[ST_DNA];
  assign clock_release_o = s_reg.st_s2[ST_CKP];

  default clocking cb @(posedge link_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_addr_byte_seen;
    byte_end && (l_reg.state == ST_ADDR);
  endsequence

  sequence s_plain_byte;
    byte_end && !cfg[CFG_ADDRESS_HOLD_ENABLE] && !cfg[CFG_DATA_HOLD_ENABLE];
  endsequence

  a_start_resets: assert property (start_det |=> l_reg.start && !l_reg.stop &&
    (l_reg.state == ST_ADDR) && (l_reg.bitcnt == 3'h0))
    else $error("start did not reset receive logic");
  a_stop_idles: assert property (stop_det && !start_det |=>
    l_reg.stop && (l_reg.state == ST_IDLE) && !l_reg.sda_oe)
    else $error("stop did not idle the receiver");
  a_sda_only_ack: assert property (l_reg.sda_oe |-> l_reg.in_ack)
    else $error("data line pulled outside the acknowledge slot");
  a_mismatch_silent: assert property (s_addr_byte_seen and
    (!ten_match_any(cfg[CFG_MODE_LO], l_reg.shift, l_reg.own, l_reg.prior)) |=>
    (l_reg.state == ST_IGNORE) && !l_reg.sda_oe && $stable(l_reg.bf))
    else $error("address mismatch was not silent");
  a_auto_nack_ovf: assert property (s_plain_byte ##0 (l_reg.bf && !cfg[CFG_BUFFER_OVERWRITE_ENABLE]) |=>
    !l_reg.sda_oe)
    else $error("acknowledge given while buffer full");
  a_hold_stretch: assert property (byte_end && (l_reg.state == ST_DATA) && cfg[CFG_DATA_HOLD_ENABLE] |=>
    l_reg.irq && !l_reg.clock_release && l_reg.ackt ##1 l_reg.scl_oe)
    else $error("data hold did not stretch after eighth fall");
  a_irq_sticky: assert property (l_reg.irq && !ev[EV_IRQCLR] |=> l_reg.irq)
    else $error("interrupt flag dropped without clear");
  a_ua_holds: assert property (l_reg.ua |-> l_reg.scl_oe)
    else $error("clock released while address update pending");
  a_rack_sample: assert property (active && scl_rise && l_reg.in_ack && !start_det &&
    !stop_det |=> l_reg.rack == $past(l_reg.sda_s2))
    else $error("acknowledge level not recorded");
  a_nack_no_irq: assert property (ack_end && l_reg.hold_byte && !l_reg.sda_oe &&
    !l_reg.ua_at9 && !l_reg.irq |=> !l_reg.irq)
    else $error("interrupt set after a not-acknowledge in hold mode");

  // Arguments are passed in so that the assertion sees sampled values, not updated ones.
  function automatic logic ten_match_any(input logic ten_mode, input logic [7:0] rx,
    input logic [7:0] addr, input logic prior_ok);
    if (!ten_mode)
      return rx[7:1] == addr[7:1];
    return (rx[7:3] == TEN_HI_PATTERN) && (rx[2:1] == addr[2:1]) && (!rx[0] || prior_ok);
  endfunction
endmodule

// *** dv/isr_master_model.sv ***
// Behavioural two-wire bus master that clocks the slave receiver.
`timescale 1ns/1ps
module isr_master_model
(
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_low_o,
  output logic sda_low_o,
  output logic stall_o
);
  localparam time HALF = 400ns;

  initial
  begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
    stall_o = 1'b0;
  end

  // A stretch longer than the bound is flagged rather than waited on forever.
  task automatic rise();
    int n;
    scl_low_o = 1'b0;
    n = 0;
    while (scl_i !== 1'b1 && n < 400)
    begin
      #10ns;
      n++;
    end
    if (n == 400)
      stall_o = 1'b1;
    #HALF;
  endtask

  // Data moves only well after the clock fall, so no false Start or Stop is seen.
  task automatic put(input logic b);
    #100ns;
    sda_low_o = !b;
    #HALF;
    rise();
  endtask

  task automatic start();
    put(1'b1);
    sda_low_o = 1'b1;
    #HALF;
    scl_low_o = 1'b1;
  endtask

  task automatic stop();
    put(1'b0);
    sda_low_o = 1'b0;
    #HALF;
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      put(d[i]);
      scl_low_o = 1'b1;
    end
    put(1'b1);
    ack = sda_i;
    scl_low_o = 1'b1;
  endtask
endmodule

// *** dv/isr_slave_tb.sv ***
// Self-checking bench for the two-wire slave receiver.
`timescale 1ns/1ps
module isr_slave_tb;
  import isr_pkg::*;
  logic clk_i;
  logic sys_rst_i;
  logic link_clk;
  logic [1:0] mode;
  logic [6:0] cfg;
  logic [7:0] own;
  logic [4:0] ev;
  wire [10:0] f;
  wire [7:0] sbuf;
  wire scl_oe;
  wire sda_oe;
  wire m_scl;
  wire m_sda;
  wire stall;
  wire scl_lvl;
  wire sda_lvl;
  wire scl_w = !(m_scl | scl_oe);
  wire sda_w = !(m_sda | sda_oe);
  int err_count = 0;
  int cmp_count = 0;

  isr_slave i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link_clk_i(link_clk),
    .scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_lvl), .scl_oe_o(scl_oe), .sda_o(sda_lvl),
    .sda_oe_o(sda_oe),
    .port_mode_select_i(mode), .start_irq_enable_i(cfg[CFG_START_IE]),
    .stop_irq_enable_i(cfg[CFG_STOP_IE]), .address_hold_enable_i(cfg[CFG_ADDRESS_HOLD_ENABLE]),
    .data_hold_enable_i(cfg[CFG_DATA_HOLD_ENABLE]), .stretch_enable_i(cfg[CFG_SEN]),
    .buffer_overwrite_enable_i(cfg[CFG_BUFFER_OVERWRITE_ENABLE]), .ack_value_select_i(cfg[CFG_ACKVAL]),
    .own_address_wr_i(ev[0]), .own_address_i(own), .clock_release_set_i(ev[1]),
    .port_interrupt_clr_i(ev[2]), .shift_buffer_rd_i(ev[3]), .receive_overflow_clr_i(ev[4]),
    .shift_buffer_o(sbuf), .port_interrupt_flag_o(f[0]), .buffer_full_o(f[1]),
    .receive_overflow_o(f[2]), .received_ack_flag_o(f[3]), .ack_phase_flag_o(f[4]),
    .address_update_needed_o(f[5]), .start_detected_o(f[6]), .stop_detected_o(f[7]),
    .read_write_o(f[8]), .data_not_address_o(f[9]), .clock_release_o(f[10]));

  isr_master_model i_master (.scl_i(scl_w), .sda_i(sda_w), .scl_low_o(m_scl),
    .sda_low_o(m_sda), .stall_o(stall));

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = !clk_i;
  end

  initial
  begin
    link_clk = 1'b0;
    #3;
    forever #16 link_clk = !link_clk;
  end

  task automatic complete_run();
    $display("Compares %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [10:0] g, input logic [10:0] e);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, g, e);
    end
  endtask

  // Status crosses back in about four link cycles, so thirty system cycles is ample.
  task automatic settle();
    repeat (30) @(negedge clk_i);
  endtask

  // Strobes are spaced well apart so two of a kind never merge in the crossing.
  task automatic sw(input logic [4:0] m);
    @(negedge clk_i);
    ev = m;
    @(negedge clk_i);
    ev = 5'h00;
    settle();
  endtask

  task automatic wb(input logic [7:0] d, input logic e);
    logic a;
    i_master.wbyte(d, a);
    settle();
    chk({10'h000, a}, {10'h000, e});
  endtask

  task automatic hb(input logic [7:0] d, input logic v, input logic [10:0] e);
    logic a;
    fork
      i_master.wbyte(d, a);
      begin
        // Eight bits take about seven microseconds before the hold interrupt can appear.
        for (int n = 0; n < 2000 && f[0] !== 1'b1; n++)
          @(negedge clk_i);
        if (f[0] !== 1'b1)
        begin
          err_count++;
          $display("CHECK FAILED t=%0t no interrupt at acknowledge time", $time);
          complete_run();
        end
        repeat (4) @(negedge clk_i);
        chk(f & 11'h611, e);
        cfg[CFG_ACKVAL] = v;
        sw(5'h06);
      end
    join
    settle();
    chk({10'h000, a}, {10'h000, v});
    chk(f & 11'h001, {10'h000, !v});
  endtask

  initial
  begin
    #1ms;
    err_count++;
    complete_run();
  end

  initial
  begin
    sys_rst_i = 1'b1;
    mode = MODE_7BIT;
    cfg = 7'h00;
    own = 8'h00;
    ev = 5'h00;
    repeat (6) @(negedge clk_i);
    sys_rst_i = 1'b0;
    chk(f, 11'h400);
    chk({3'h0, sbuf}, 11'h000);
    for (int m = 0; m < 5; m++)
    begin
      mode = 2'(m);
      cfg[CFG_START_IE] = (m == 4);
      cfg[CFG_STOP_IE] = (m == 4);
      i_master.start();
      settle();
      chk(f & 11'h0C1, 11'h040 | 11'(m >= 2));
      sw(5'h04);
      i_master.stop();
      settle();
      chk(f & 11'h0C1, 11'h080 | 11'(m >= 2));
      sw(5'h04);
    end
    mode = MODE_7BIT;
    cfg = 7'h00;
    own = 8'hA4;
    sw(5'h01);
    cfg[CFG_SEN] = 1'b1;
    i_master.start();
    wb(8'hA4, 1'b0);
    chk(f & 11'h70F, 11'h003);
    chk({3'h0, sbuf}, 11'h0A4);
    chk({10'h000, scl_oe}, 11'h001);
    sw(5'h0C);
    chk(f & 11'h003, 11'h000);
    sw(5'h02);
    chk({scl_oe, f[10]}, 11'h001);
    wb(8'h3C, 1'b0);
    chk(f & 11'h203, 11'h203);
    chk({3'h0, sbuf}, 11'h03C);
    sw(5'h06);
    wb(8'hC3, 1'b1);
    chk(f & 11'h00E, 11'h00E);
    chk({3'h0, sbuf}, 11'h03C);
    sw(5'h1E);
    chk(f & 11'h006, 11'h000);
    cfg[CFG_BUFFER_OVERWRITE_ENABLE] = 1'b1;
    wb(8'h11, 1'b0);
    sw(5'h06);
    wb(8'h22, 1'b0);
    chk(f & 11'h006, 11'h006);
    chk({3'h0, sbuf}, 11'h022);
    sw(5'h1E);
    cfg[CFG_BUFFER_OVERWRITE_ENABLE] = 1'b0;
    i_master.stop();
    @(negedge clk_i);
    cfg[CFG_SEN] = 1'b0;
    i_master.start();
    wb(8'h12, 1'b1);
    chk(f & 11'h003, 11'h000);
    i_master.start();
    wb(8'hA5, 1'b0);
    chk(f & 11'h103, 11'h103);
    sw(5'h0E);
    i_master.start();
    wb(8'hA4, 1'b0);
    chk(f & 11'h103, 11'h003);
    sw(5'h0C);
    i_master.stop();
    @(negedge clk_i);
    cfg[CFG_ADDRESS_HOLD_ENABLE] = 1'b1;
    cfg[CFG_DATA_HOLD_ENABLE] = 1'b1;
    i_master.start();
    hb(8'hA4, 1'b0, 11'h011);
    sw(5'h0C);
    hb(8'h5A, 1'b1, 11'h211);
    i_master.stop();
    @(negedge clk_i);
    cfg = 7'h00;
    mode = MODE_10BIT;
    own = 8'hF6;
    sw(5'h0D);
    for (int k = 0; k < 2; k++)
    begin
      i_master.start();
      wb(8'hF6, 1'b0);
      chk(f & 11'h021, 11'h021);
      chk({10'h000, scl_oe}, 11'h001);
      own = 8'h5A;
      sw(5'h0D);
      chk(f & 11'h020, 11'h000);
      wb(8'h5A + 8'(k), 1'(k));
      chk(f & 11'h023, 11'h023 ^ 11'(k << 1));
      own = 8'hF6;
      sw(5'h0D);
    end
    i_master.stop();
    i_master.start();
    wb(8'hF6, 1'b0);
    own = 8'h5A;
    sw(5'h0D);
    wb(8'h5A, 1'b0);
    own = 8'hF6;
    sw(5'h0D);
    wb(8'h77, 1'b0);
    chk({3'h0, sbuf}, 11'h077);
    sw(5'h0C);
    i_master.start();
    wb(8'hF7, 1'b0);
    chk(f & 11'h101, 11'h101);
    sw(5'h0E);
    i_master.stop();
    chk({10'h000, stall}, 11'h000);
    chk({9'h000, scl_lvl, sda_lvl}, 11'h000);
    complete_run();
  end
endmodule
